// ==== vpr_regs.sv ====
// Purpose: Control and status registers of the video preamp, reached over a two-wire serial slave
// Assumes: ref_clk_in well above the serial bit rate; the master drives the serial clock
// Notes:   Control fields leave registered one cycle after the register write
//
// Summary of operation
// - Green and blue gain: 7-bit fields
// - Contrast: 7-bit field scaling all channels
// - Three bias codes, full 8 bits each
// - Black level: 8-bit code, inverse sense
// - Reference offset: 4 bits, upper bits unused
// - Global bit 7 disables address auto-increment
// - Global bit 5 halves bias range
// - Global bit 4 enables vertical blanking
// - Global bit 3 selects clamp pulse polarity
// - Global bit 2 enables horizontal blanking
// - Global bit 1 requests low power
// - Global bit 0 forces outputs to blank
// - Overlay background: 7-bit video amount
// - Overlay bit 7: show overlay only
// - Bit 5 forces full gain, analog only
// - Overlay bit 4 selects analog inputs
// - Overlay bit 3 selects see-through background
// - Soft reset restores defaults, then self-clears
// - Status bit 3: vertical fault, blanks video
// - Sticky overvoltage bit; flyback fault bit
// - Status bit 0: sync present and locked
// - Horizontal phase: 8-bit picture position
// - Write: device, register, then data bytes
// - Read: set address, restart, stream data
`timescale 1ns/100ps
`include "vpr_defs.svh"
module vpr_regs (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  ce_in,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  input  wire vpr_pkg::vpr_stat_type stat_in,
  output logic                       sda_out,
  output logic                       sda_oe_out,
  output vpr_pkg::vpr_ctrl_type      ctrl_out
);
  import vpr_pkg::*;

  logic [`VPR_SYNC_W-1:0] sync_s;
  logic                   scl_s;
  logic                   sda_s;
  vpr_stat_type           stat_s;
  logic                   scl_d_r;
  logic                   sda_d_r;
  logic                   start_det;
  logic                   stop_det;
  logic                   scl_rise;
  logic                   scl_fall;

  vpr_state_type          state_r;
  logic [3:0]             bit_cnt_r;
  logic [7:0]             rx_shift_r;
  logic [7:0]             tx_shift_r;
  logic                   read_mode_r;
  logic                   master_nack_r;
  logic [7:0]             reg_ptr_r;
  logic [7:0]             rd_data;
  logic                   wr_en;
  logic                   ptr_load;
  logic                   rd_done;
  logic                   autoinc_on;

  logic [7:0]             green_r;
  logic [7:0]             blue_r;
  logic [7:0]             contrast_r;
  logic [7:0]             bias1_r;
  logic [7:0]             bias2_r;
  logic [7:0]             bias3_r;
  logic [7:0]             black_r;
  logic [7:0]             refofs_r;
  logic [7:0]             global_r;
  logic [7:0]             ovl_bg_r;
  logic [7:0]             ovl_ctl_r;
  logic [7:0]             hphase_r;
  logic                   soft_reset_r;
  logic                   overvoltage_r;
  vpr_ctrl_type           ctrl_r;

  // Pins and analog flags are asynchronous to ref_clk_in
  // Bus lines pass inverted so a cleared synchroniser reads as an idle high bus, avoiding a false edge after reset
  vpr_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .din_in     ({stat_in, ~sda_in, ~scl_in}),
    .dout_out   (sync_s)
  );

  assign scl_s  = ~sync_s[0];
  assign sda_s  = ~sync_s[1];
  assign stat_s = sync_s[`VPR_SYNC_W-1:2];

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (ce_in) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;

  // Byte-level events, valid only when no start or stop is seen
  assign ptr_load   = ~start_det & ~stop_det & scl_fall & (state_r == ST_REGADR) & (bit_cnt_r == 4'h8);
  assign wr_en      = ~start_det & ~stop_det & scl_fall & (state_r == ST_WRBYTE) & (bit_cnt_r == 4'h8);
  assign rd_done    = ~start_det & ~stop_det & scl_fall & (state_r == ST_RDBYTE) & (bit_cnt_r == 4'h7);
  assign autoinc_on = ~global_r[`VPR_GLB_AUTOINC_DIS];

  // Serial engine: address, acknowledge and byte framing
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r       <= ST_IDLE;
      bit_cnt_r     <= 4'h0;
      rx_shift_r    <= 8'h00;
      tx_shift_r    <= 8'h00;
      read_mode_r   <= 1'b0;
      master_nack_r <= 1'b0;
    end else if (ce_in) begin
      if (start_det) begin
        // A repeated start restarts framing from the device address
        state_r   <= ST_DEVADR;
        bit_cnt_r <= 4'h0;
      end else if (stop_det) begin
        state_r   <= ST_IDLE;
        bit_cnt_r <= 4'h0;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            bit_cnt_r <= 4'h0;
          end
          ST_DEVADR, ST_REGADR, ST_WRBYTE: begin
            if (scl_rise && bit_cnt_r != 4'h8) begin
              rx_shift_r <= {rx_shift_r[6:0], sda_s};
              bit_cnt_r  <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (state_r == ST_DEVADR) begin
                // Other addresses on the bus are left alone
                if (rx_shift_r[7:1] == `VPR_DEV_ADDR) begin
                  state_r <= ST_DEVACK;
                end else begin
                  state_r <= ST_IDLE;
                end
                read_mode_r <= rx_shift_r[0];
              end else if (state_r == ST_REGADR) begin
                state_r <= ST_REGACK;
              end else begin
                state_r <= ST_WRACK;
              end
            end
          end
          ST_DEVACK: begin
            if (scl_fall) begin
              if (read_mode_r) begin
                state_r    <= ST_RDBYTE;
                tx_shift_r <= rd_data;
                bit_cnt_r  <= 4'h0;
              end else begin
                state_r <= ST_REGADR;
              end
            end
          end
          ST_REGACK, ST_WRACK: begin
            if (scl_fall) begin
              state_r <= ST_WRBYTE;
            end
          end
          ST_RDBYTE: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h7) begin
                state_r <= ST_RDACK;
              end else begin
                tx_shift_r <= {tx_shift_r[6:0], 1'b0};
                bit_cnt_r  <= bit_cnt_r + 4'h1;
              end
            end
          end
          ST_RDACK: begin
            if (scl_rise) begin
              master_nack_r <= sda_s;
            end else if (scl_fall) begin
              if (master_nack_r) begin
                // Master ends the read; wait for its stop
                state_r <= ST_IDLE;
              end else begin
                state_r    <= ST_RDBYTE;
                tx_shift_r <= rd_data;
                bit_cnt_r  <= 4'h0;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Pointer survives a stop so that a following read starts where it was set
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_ptr_r <= 8'h00;
    end else if (ce_in) begin
      if (ptr_load) begin
        reg_ptr_r <= rx_shift_r;
      end else if ((wr_en || rd_done) && autoinc_on) begin
        reg_ptr_r <= reg_ptr_r + 8'h01;
      end
    end
  end

  // Open drain: only low is driven
  assign sda_out    = 1'b0;
  assign sda_oe_out = (state_r == ST_DEVACK) | (state_r == ST_REGACK) | (state_r == ST_WRACK) |
                      ((state_r == ST_RDBYTE) & ~tx_shift_r[7]);

  // Software reset runs for one cycle; the serial engine is left running
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      soft_reset_r <= 1'b0;
    end else if (ce_in) begin
      soft_reset_r <= wr_en & (reg_ptr_r == `VPR_OFS_SRESET) & rx_shift_r[`VPR_SOFT_RESET_REQUEST_BIT];
    end
  end

  // Control registers; unused bits are masked on write so they read back zero
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      green_r    <= `VPR_RST_GAIN;
      blue_r     <= `VPR_RST_GAIN;
      contrast_r <= `VPR_RST_GAIN;
      bias1_r    <= `VPR_RST_BIAS;
      bias2_r    <= `VPR_RST_BIAS;
      bias3_r    <= `VPR_RST_BIAS;
      black_r    <= `VPR_RST_BLACK;
      refofs_r   <= `VPR_RST_REFOFS;
      global_r   <= `VPR_RST_GLOBAL;
      ovl_bg_r   <= `VPR_RST_OVL_BG;
      ovl_ctl_r  <= `VPR_RST_OVL_CTL;
      hphase_r   <= `VPR_RST_HPHASE;
    end else if (ce_in) begin
      if (soft_reset_r) begin
        green_r    <= `VPR_RST_GAIN;
        blue_r     <= `VPR_RST_GAIN;
        contrast_r <= `VPR_RST_GAIN;
        bias1_r    <= `VPR_RST_BIAS;
        bias2_r    <= `VPR_RST_BIAS;
        bias3_r    <= `VPR_RST_BIAS;
        black_r    <= `VPR_RST_BLACK;
        refofs_r   <= `VPR_RST_REFOFS;
        global_r   <= `VPR_RST_GLOBAL;
        ovl_bg_r   <= `VPR_RST_OVL_BG;
        ovl_ctl_r  <= `VPR_RST_OVL_CTL;
        hphase_r   <= `VPR_RST_HPHASE;
      end else if (wr_en) begin
        unique case (reg_ptr_r)
          `VPR_OFS_GREEN:    green_r    <= rx_shift_r & `VPR_MSK_7BIT;
          `VPR_OFS_BLUE:     blue_r     <= rx_shift_r & `VPR_MSK_7BIT;
          `VPR_OFS_CONTRAST: contrast_r <= rx_shift_r & `VPR_MSK_7BIT;
          `VPR_OFS_BIAS1:    bias1_r    <= rx_shift_r & `VPR_MSK_FULL;
          `VPR_OFS_BIAS2:    bias2_r    <= rx_shift_r & `VPR_MSK_FULL;
          `VPR_OFS_BIAS3:    bias3_r    <= rx_shift_r & `VPR_MSK_FULL;
          `VPR_OFS_BLACK:    black_r    <= rx_shift_r & `VPR_MSK_FULL;
          `VPR_OFS_REFOFS:   refofs_r   <= rx_shift_r & `VPR_MSK_REFOFS;
          `VPR_OFS_GLOBAL:   global_r   <= rx_shift_r & `VPR_MSK_GLOBAL;
          `VPR_OFS_OVL_BG:   ovl_bg_r   <= rx_shift_r & `VPR_MSK_7BIT;
          `VPR_OFS_OVL_CTL:  ovl_ctl_r  <= rx_shift_r & `VPR_MSK_OVL_CTL;
          `VPR_OFS_HPHASE:   hphase_r   <= rx_shift_r & `VPR_MSK_FULL;
          // Status, the reset bit and unmapped offsets keep their contents
          default: begin
          end
        endcase
      end
    end
  end

  // Overvoltage latches; a trip in the same cycle as supply collapse wins
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      overvoltage_r <= 1'b0;
    end else if (ce_in) begin
      if (stat_s.overvoltage_trip) begin
        overvoltage_r <= 1'b1;
      end else if (stat_s.supply_collapse) begin
        overvoltage_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_data = 8'h00;
    unique case (reg_ptr_r)
      `VPR_OFS_GREEN:    rd_data = green_r;
      `VPR_OFS_BLUE:     rd_data = blue_r;
      `VPR_OFS_CONTRAST: rd_data = contrast_r;
      `VPR_OFS_BIAS1:    rd_data = bias1_r;
      `VPR_OFS_BIAS2:    rd_data = bias2_r;
      `VPR_OFS_BIAS3:    rd_data = bias3_r;
      `VPR_OFS_BLACK:    rd_data = black_r;
      `VPR_OFS_REFOFS:   rd_data = refofs_r;
      `VPR_OFS_GLOBAL:   rd_data = global_r;
      `VPR_OFS_OVL_BG:   rd_data = ovl_bg_r;
      `VPR_OFS_OVL_CTL:  rd_data = ovl_ctl_r;
      `VPR_OFS_SRESET:   rd_data = {7'h00, soft_reset_r};
      `VPR_OFS_STATUS:   rd_data = {4'h0,
                                    stat_s.vert_fault_flag,
                                    overvoltage_r,
                                    stat_s.flyback_fault_flag,
                                    stat_s.hsync_present & stat_s.line_pll_locked};
      `VPR_OFS_HPHASE:   rd_data = hphase_r;
      default:           rd_data = 8'h00;
    endcase
  end

  // Registered fan-out to the analog section
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= '0;
    end else if (ce_in) begin
      ctrl_r.green_level              <= green_r[6:0];
      ctrl_r.blue_level               <= blue_r[6:0];
      ctrl_r.contrast_level           <= contrast_r[6:0];
      ctrl_r.bias_level_one           <= bias1_r;
      ctrl_r.bias_level_two           <= bias2_r;
      ctrl_r.bias_level_three         <= bias3_r;
      ctrl_r.black_level              <= black_r;
      ctrl_r.black_reference_code     <= refofs_r[3:0];
      ctrl_r.bias_range_half          <= global_r[`VPR_GLB_BIAS_HALF];
      ctrl_r.vert_blank_enable        <= global_r[`VPR_GLB_VBLANK];
      ctrl_r.clamp_active_low         <= global_r[`VPR_GLB_CLAMP_LOW];
      ctrl_r.horiz_blank_enable       <= global_r[`VPR_GLB_HBLANK];
      ctrl_r.low_power_request        <= global_r[`VPR_GLB_LOW_POWER];
      // A tripped vertical protection blanks the outputs as well
      ctrl_r.force_blank              <= global_r[`VPR_GLB_FORCE_BLANK] |
                                         stat_s.vert_fault_flag;
      ctrl_r.overlay_background_level <= ovl_bg_r[6:0];
      ctrl_r.overlay_only             <= ovl_ctl_r[`VPR_OVL_ONLY];
      ctrl_r.overlay_full_gain        <= ovl_ctl_r[`VPR_OVL_FULL_GAIN] &
                                         ovl_ctl_r[`VPR_OVL_ANALOG];
      ctrl_r.overlay_analog_select    <= ovl_ctl_r[`VPR_OVL_ANALOG];
      ctrl_r.see_through_background   <= ovl_ctl_r[`VPR_OVL_SEE_THROUGH];
      ctrl_r.overlay_level_select     <= ovl_ctl_r[1:0];
      ctrl_r.soft_reset_active        <= soft_reset_r;
      ctrl_r.line_phase_setting       <= hphase_r;
    end
  end

  assign ctrl_out = ctrl_r;

endmodule : vpr_regs

// ==== vpr_defs.svh ====
// Purpose: Offsets, field positions, reset values and masks of the preamp control registers
// Assumes: 8-bit registers behind a serial two-wire slave
// Notes:   Definitions only
`ifndef VPR_DEFS_SVH
`define VPR_DEFS_SVH

`define VPR_SYNC_W        8
`define VPR_DEV_ADDR      7'h5D

`define VPR_OFS_GREEN     8'h01
`define VPR_OFS_BLUE      8'h02
`define VPR_OFS_CONTRAST  8'h03
`define VPR_OFS_BIAS1     8'h04
`define VPR_OFS_BIAS2     8'h05
`define VPR_OFS_BIAS3     8'h06
`define VPR_OFS_BLACK     8'h07
`define VPR_OFS_REFOFS    8'h08
`define VPR_OFS_GLOBAL    8'h09
`define VPR_OFS_OVL_BG    8'h0A
`define VPR_OFS_OVL_CTL   8'h0B
`define VPR_OFS_SRESET    8'h0C
`define VPR_OFS_STATUS    8'h40
`define VPR_OFS_HPHASE    8'h41

`define VPR_RST_GAIN      8'h60
`define VPR_RST_BIAS      8'h00
`define VPR_RST_BLACK     8'h80
`define VPR_RST_REFOFS    8'h0C
`define VPR_RST_GLOBAL    8'h00
`define VPR_RST_OVL_BG    8'h00
`define VPR_RST_OVL_CTL   8'h02
`define VPR_RST_HPHASE    8'h40

`define VPR_MSK_7BIT      8'h7F
`define VPR_MSK_FULL      8'hFF
`define VPR_MSK_REFOFS    8'h0F
`define VPR_MSK_GLOBAL    8'hBF
`define VPR_MSK_OVL_CTL   8'hBB

`define VPR_GLB_AUTOINC_DIS 7
`define VPR_GLB_BIAS_HALF   5
`define VPR_GLB_VBLANK      4
`define VPR_GLB_CLAMP_LOW   3
`define VPR_GLB_HBLANK      2
`define VPR_GLB_LOW_POWER   1
`define VPR_GLB_FORCE_BLANK 0

`define VPR_OVL_ONLY        7
`define VPR_OVL_FULL_GAIN   5
`define VPR_OVL_ANALOG      4
`define VPR_OVL_SEE_THROUGH 3

`define VPR_SOFT_RESET_REQUEST_BIT        0

`endif

// ==== vpr_pkg.sv ====
// Purpose: Types shared by the preamp control register block
// Assumes: Constants come from vpr_defs.svh
// Notes:   Control fields leave as one packed struct
package vpr_pkg;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_DEVADR = 9'h002,
    ST_DEVACK = 9'h004,
    ST_REGADR = 9'h008,
    ST_REGACK = 9'h010,
    ST_WRBYTE = 9'h020,
    ST_WRACK  = 9'h040,
    ST_RDBYTE = 9'h080,
    ST_RDACK  = 9'h100
  } vpr_state_type;

  typedef struct packed {
    logic vert_fault_flag;
    logic overvoltage_trip;
    logic supply_collapse;
    logic flyback_fault_flag;
    logic hsync_present;
    logic line_pll_locked;
  } vpr_stat_type;

  typedef struct packed {
    logic [6:0] green_level;
    logic [6:0] blue_level;
    logic [6:0] contrast_level;
    logic [7:0] bias_level_one;
    logic [7:0] bias_level_two;
    logic [7:0] bias_level_three;
    logic [7:0] black_level;
    logic [3:0] black_reference_code;
    logic       bias_range_half;
    logic       vert_blank_enable;
    logic       clamp_active_low;
    logic       horiz_blank_enable;
    logic       low_power_request;
    logic       force_blank;
    logic [6:0] overlay_background_level;
    logic       overlay_only;
    logic       overlay_full_gain;
    logic       overlay_analog_select;
    logic       see_through_background;
    logic [1:0] overlay_level_select;
    logic       soft_reset_active;
    logic [7:0] line_phase_setting;
  } vpr_ctrl_type;

endpackage : vpr_pkg

// ==== vpr_sync.sv ====
// Purpose: Two-flop synchroniser for every asynchronous input of the block
// Assumes: Inputs are levels from pins or analog comparators
// Notes:   Only the second stage leaves the module
`timescale 1ns/100ps
`include "vpr_defs.svh"
module vpr_sync (
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   ce_in,
  input  wire logic [`VPR_SYNC_W-1:0] din_in,
  output logic      [`VPR_SYNC_W-1:0] dout_out
);
  import vpr_pkg::*;

  logic [`VPR_SYNC_W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < `VPR_SYNC_W; i++) begin : g_bit
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          meta_r[i]   <= 1'b0;
          dout_out[i] <= 1'b0;
        end else if (ce_in) begin
          meta_r[i]   <= din_in[i];
          dout_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule : vpr_sync

// ==== vpr_regs_props.sv ====
// Purpose: Port-level checks of the preamp control registers
// Assumes: SCL phases of at least 8 clocks
// Notes:   Bound into every vpr_regs
`timescale 1ns/100ps
module vpr_regs_props (
  input wire logic                  ref_clk_in,
  input wire logic                  rst_in,
  input wire logic                  ce_in,
  input wire logic                  scl_in,
  input wire logic                  sda_in,
  input wire vpr_pkg::vpr_stat_type stat_in,
  input wire logic                  sda_out,
  input wire logic                  sda_oe_out,
  input wire vpr_pkg::vpr_ctrl_type ctrl_out
);
  import vpr_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  boot_defaults_a: assert property ($fell(rst_in) && ce_in |=>
    ctrl_out.green_level == 7'h60 && ctrl_out.black_level == 8'h80) else $error("defaults missing after reset");
  soft_reset_request_self_clear_a: assert property (ctrl_out.soft_reset_active |=> !ctrl_out.soft_reset_active)
    else $error("soft reset did not clear");
  soft_reset_request_defaults_a: assert property ($fell(ctrl_out.soft_reset_active) |-> {ctrl_out.contrast_level,
    ctrl_out.black_reference_code, ctrl_out.line_phase_setting, ctrl_out.overlay_level_select} ==
    {7'h60, 4'hC, 8'h40, 2'b10}) else $error("soft reset left non-default fields");
  fault_blanks_a: assert property ((ce_in && stat_in.vert_fault_flag)[*5] |-> ctrl_out.force_blank)
    else $error("vertical fault did not blank");
  full_gain_analog_a: assert property (ctrl_out.overlay_full_gain |-> ctrl_out.overlay_analog_select)
    else $error("full gain outside analog mode");
  freeze_hold_a: assert property (!ce_in |=> $stable(ctrl_out) && $stable(sda_oe_out))
    else $error("state moved while clock enable low");
  ack_low_phase_a: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("SDA pulled while SCL high");
  ack_stands_a: assert property (scl_in[*5] |-> $stable(sda_oe_out))
    else $error("SDA drive changed in SCL high phase");
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("open drain value not low");
endmodule : vpr_regs_props
bind vpr_regs vpr_regs_props i_props (.ref_clk_in, .rst_in, .ce_in, .scl_in, .sda_in, .stat_in, .sda_out,
  .sda_oe_out, .ctrl_out);

// ==== vpr_host.sv ====
// Purpose: Two-wire bus master standing in for the system microcontroller
// Assumes: SDA is resolved outside with a pull-up
// Notes:   SDA only moves 4 clocks after SCL falls, so no false start or stop
`timescale 1ns/100ps
module vpr_host #(
  parameter int HALF = 10
) (
  input  wire logic ref_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  initial scl_out = 1'b1;
  initial sda_oe_out = 1'b0;
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask : step
  task automatic put_bit(input logic b);
    step(4);
    sda_oe_out = !b;
    step(HALF);
    scl_out = 1'b1;
    step(HALF);
    scl_out = 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    step(4);
    sda_oe_out = 1'b0;
    step(HALF);
    scl_out = 1'b1;
    step(HALF);
    b = sda_in;
    scl_out = 1'b0;
  endtask : get_bit
  task automatic start();
    step(4);
    sda_oe_out = 1'b0;
    step(HALF);
    scl_out = 1'b1;
    step(HALF);
    sda_oe_out = 1'b1;
    step(HALF);
    scl_out = 1'b0;
  endtask : start
  task automatic stop();
    step(4);
    sda_oe_out = 1'b1;
    step(HALF);
    scl_out = 1'b1;
    step(HALF);
    sda_oe_out = 1'b0;
    step(HALF);
  endtask : stop
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack);
    ack = !ack;
  endtask : send
  task automatic recv(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask : recv
endmodule : vpr_host

// ==== tb_video_preamp_control_registers.sv ====
// Purpose: Self-checking bench of the preamp control registers
// Assumes: Host model drives the bus; SDA has a pull-up
// Notes:   Reads use an address-only write, a stop and a new start
`timescale 1ns/100ps
module tb_video_preamp_control_registers;
  import vpr_pkg::*;
  logic         ref_clk_in = 1'b0;
  logic         rst_in = 1'b1;
  logic         ce_in = 1'b1;
  vpr_stat_type stat_in = '0;
  vpr_ctrl_type ctrl_out;
  logic         scl, sda, host_oe, dut_oe, a;
  logic [7:0]   v;
  logic [7:0]   wq [16];
  logic [7:0]   rq [16];
  logic [7:0]   dflt [12] = '{8'h60, 8'h60, 8'h60, 8'h00, 8'h00, 8'h00, 8'h80, 8'h0C, 8'h00, 8'h00, 8'h02, 8'h00};
  logic [7:0]   full [11] = '{8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h3F, 8'h7F, 8'hBB};
  int           bad_count = 0;
  int           samples_checked = 0;
  always #10 ref_clk_in = !ref_clk_in;
  assign sda = !(host_oe || dut_oe);
  vpr_regs i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in), .scl_in(scl), .sda_in(sda),
    .stat_in(stat_in), .sda_out(), .sda_oe_out(dut_oe), .ctrl_out(ctrl_out));
  vpr_host i_host (.ref_clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic ack_ok(input logic [7:0] d);
    i_host.send(d, a);
    check({7'h0, a}, 8'h01);
  endtask : ack_ok
  task automatic wr(input logic [7:0] ofs, input int n);
    i_host.start();
    ack_ok(8'hBA);
    ack_ok(ofs);
    for (int i = 0; i < n; i++) ack_ok(wq[i]);
    i_host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] ofs, input int n);
    i_host.start();
    ack_ok(8'hBA);
    ack_ok(ofs);
    i_host.stop();
    i_host.start();
    ack_ok(8'hBB);
    for (int i = 0; i < n; i++) i_host.recv(rq[i], i == n - 1);
    i_host.stop();
  endtask : rd
  task automatic report_and_stop();
    $display("counts: %0d checked, %0d unexpected", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (90000) @(posedge ref_clk_in);
    bad_count++;
    $display("unexpected at %0t: run did not finish", $time);
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge ref_clk_in);
    #2 rst_in = 1'b0;
    repeat (8) @(posedge ref_clk_in);
    rd(8'h01, 12);
    for (int i = 0; i < 12; i++) check(rq[i], dflt[i]);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) wq[i] = 8'hFF;
    wr(8'h01, 8);
    wr(8'h0A, 2);
    wq[0] = 8'h7F;
    wr(8'h09, 1);
    rd(8'h01, 11);
    for (int i = 0; i < 11; i++) check(rq[i], full[i]);
    v = {2'b0, ctrl_out.bias_range_half, ctrl_out.vert_blank_enable, ctrl_out.clamp_active_low,
      ctrl_out.horiz_blank_enable, ctrl_out.low_power_request, ctrl_out.force_blank};
    check(v, 8'h3F);
    v = {ctrl_out.overlay_only, ctrl_out.overlay_full_gain, ctrl_out.overlay_analog_select,
      ctrl_out.see_through_background, ctrl_out.black_reference_code};
    check(v, 8'hFF);
    wq[0] = 8'h20;
    wr(8'h0B, 1);
    check({6'h0, ctrl_out.overlay_full_gain, ctrl_out.overlay_analog_select}, 8'h00);
    $display("test full codes done");
    wq[0] = 8'h80;
    wr(8'h09, 1);
    wq[0] = 8'h11;
    wq[1] = 8'h22;
    wr(8'h02, 2);
    rd(8'h02, 2);
    check(rq[0], 8'h22);
    check(rq[1], 8'h22);
    wq[0] = 8'h00;
    wr(8'h09, 1);
    rd(8'h02, 2);
    check(rq[1], 8'h7F);
    $display("test auto-increment done");
    ce_in = 1'b0;
    stat_in = 6'b110110;
    repeat (20) @(posedge ref_clk_in);
    #2 check({7'h0, ctrl_out.force_blank}, 8'h00);
    ce_in = 1'b1;
    repeat (10) @(posedge ref_clk_in);
    #2 stat_in = 6'b100110;
    check({7'h0, ctrl_out.force_blank}, 8'h01);
    wq[0] = 8'hFF;
    wr(8'h40, 1);
    wq[0] = 8'h01;
    wr(8'h0C, 1);
    rd(8'h0C, 1);
    check(rq[0], 8'h00);
    rd(8'h40, 1);
    check(rq[0], 8'h0E);
    rd(8'h02, 1);
    check(rq[0], 8'h60);
    stat_in = 6'b001011;
    repeat (10) @(posedge ref_clk_in);
    #2 stat_in = 6'b000011;
    rd(8'h40, 1);
    check(rq[0], 8'h01);
    check({7'h0, ctrl_out.force_blank}, 8'h00);
    $display("test status and soft reset done");
    wq[0] = 8'hFF;
    wr(8'h41, 1);
    wq[0] = 8'h5A;
    wr(8'h20, 1);
    rd(8'h20, 1);
    check(rq[0], 8'h00);
    rd(8'h41, 1);
    check(rq[0], 8'hFF);
    check(ctrl_out.line_phase_setting, 8'hFF);
    i_host.start();
    i_host.send(8'hB8, a);
    check({7'h0, a}, 8'h00);
    i_host.stop();
    $display("test phase and refusals done");
    report_and_stop();
  end
endmodule : tb_video_preamp_control_registers
